// ### core/ddc_defs.svh
// Purpose: named constants of the down-conversion front end
// Assumes: included by the core and the bench
// Notes:   byte offsets on a 32-bit AXI4-Lite bus
`ifndef DDC_DEFS_SVH
`define DDC_DEFS_SVH
// register byte offsets
`define DDC_A_CTRL    8'h00
`define DDC_A_DECIM   8'h04
`define DDC_A_SHIFT   8'h08
`define DDC_A_FHOLD   8'h0C
`define DDC_A_TARGET  8'h10
`define DDC_A_THRESH  8'h14
`define DDC_A_STATUS  8'h18
`define DDC_A_OUT     8'h1C
`define DDC_A_FREQ    8'h20
`define DDC_A_OFS     8'h24
// control fields
`define DDC_C_OFSBIN  0
`define DDC_C_MODE    2:1
`define DDC_C_COMP    3
`define DDC_C_SERIAL  4
`define DDC_C_AGC     5
`define DDC_C_TRACK   6
// reset values and limits
`define DDC_CTRL_RST  7'h04
`define DDC_DECIM_RST 13'h0001
`define DDC_DECIM_MAX 13'h1000
`define DDC_GAIN_RST  8'h80
`define DDC_GAIN_MAX  8'hFF
`define DDC_GAIN_MIN  8'h01
`define DDC_GAIN_FRAC 7
`define DDC_MIX_SHIFT 9
`define DDC_COMP_TAP  5'h0A
`define DDC_COMP_DIV  3
`define DDC_OFS_BITS  6'h20
`define DDC_SER_BITS  5'h10
// nco: 32-bit accumulator, 0.012 Hz per step at a 52 MHz sample rate
`define DDC_NCO_RATE_HZ  52000000
`define DDC_NCO_STEP_MHZ 12
`define DDC_PHASE_TOP    31:26
`define DDC_RESP_OK   2'b00
`define DDC_RESP_ERR  2'b10
`endif

// ### core/ddc_pkg.sv
// Purpose: types of the down-conversion front end
// Assumes: ddc_defs.svh alongside
// Notes:   none
`default_nettype none
package ddc_pkg;
  typedef enum logic [1:0] {DDC_BYPASS = 2'b00, DDC_DUMP = 2'b01, DDC_CIC3 = 2'b10}
    ddc_mode_t;
  typedef enum logic [1:0] {DDC_SER_IDLE = 2'b00, DDC_SER_SHIFT = 2'b01} ddc_ser_t;
endpackage
`default_nettype wire

// ### core/ddc_frontend.sv
// Purpose: down-conversion front end, nco mixer, gain, cic, agc, AXI4-Lite regs
// Assumes: all inputs synchronous to aclk, synchronous active-low reset
// Notes:   I and Q filter paths come from one generate loop
// How it works
// - each captured sample is multiplied by the complex nco output
// - 32-bit nco accumulator gives 0.012 Hz steps at 52 MHz
// - mixer output gain corrected, then into identical I and Q filters
// - each path decimates through a three-stage integrator-comb filter
// - mode selects integrate-and-dump or third-order cic
// - optional three-tap compensation filter after the decimator
// - bypass mode skips decimator and compensation
// - decimation factor programmable from 1 to 4096
// - decimation fixed or nudged per dump by symbol loop inputs
// - agc steps gain to hold output magnitude near target
// - input level detector drives an error output for external agc
// - output given parallel or serial as configured
// - configuration over register bus, here AXI4-Lite
// - 10-bit inputs read as two's complement or offset binary
// - samples captured on rising edge only while enable_n is low
// - two-bit phase select rotates carrier by 0/90/180/270 degrees
// - load input high copies holding register into carrier frequency
// - offset word shifted in msb first, starting cycle after sync
`include "ddc_defs.svh"
`default_nettype none
module ddc_frontend
  import ddc_pkg::*;
(
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // converter samples
  input  wire logic [9:0]  inphase_sample_in,
  input  wire logic [9:0]  quad_sample_in,
  input  wire logic        sample_capture_enable_n,
  // carrier control
  input  wire logic [1:0]  carrier_phase_select,
  input  wire logic        carrier_freq_load,
  input  wire logic        carrier_offset_serial_in,
  input  wire logic        carrier_offset_sync,
  // symbol tracking nudges
  input  wire logic        symbol_advance,
  input  wire logic        symbol_retard,
  // outputs
  output logic [15:0]      out_i_q,
  output logic [15:0]      out_q_q,
  output logic             out_ready_q,
  output logic             ser_i_q,
  output logic             ser_q_q,
  output logic             if_level_high_q
);
  // cosine at whole 1/64-turn steps, so phase zero is exactly 0 degrees
  localparam logic [9:0] COS_T [16] = '{10'h1FE, 10'h1FC, 10'h1F4, 10'h1E8,
    10'h1D7, 10'h1C2, 10'h1A8, 10'h18A, 10'h169, 10'h144, 10'h11B, 10'h0F0,
    10'h0C3, 10'h094, 10'h063, 10'h032};

  logic [6:0]  ctrl_q;
  logic [12:0] decim_q;
  logic [5:0]  shift_q;
  logic [31:0] fhold_q, freq_q, ofs_q, ofs_sh_q, phase_q;
  logic [15:0] target_q;
  logic [9:0]  thresh_q;
  logic [7:0]  gain_q;
  logic [5:0]  ofs_cnt_q;
  logic        wr_go, rd_go;
  ddc_mode_t   mode;
  assign mode  = ddc_mode_t'(ctrl_q[`DDC_C_MODE]);
  assign wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
  assign rd_go = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;

  // write channel: address and data taken together, response next cycle
  always_ff @(posedge aclk)
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `DDC_RESP_OK;
    end
    else
    begin
      s_axi_awready <= wr_go;
      s_axi_wready  <= wr_go;
      if (wr_go)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (s_axi_awaddr > `DDC_A_THRESH) ? `DDC_RESP_ERR : `DDC_RESP_OK;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end

  // writable registers, all byte enables honoured for fhold, only wstrb[0] checked elsewhere
  always_ff @(posedge aclk)
    if (!aresetn)
    begin
      ctrl_q   <= `DDC_CTRL_RST;
      decim_q  <= `DDC_DECIM_RST;
      shift_q  <= '0;
      fhold_q  <= '0;
      target_q <= '0;
      thresh_q <= '0;
    end
    else if (wr_go)
      unique case (s_axi_awaddr)
        `DDC_A_CTRL:   if (s_axi_wstrb[0]) ctrl_q <= s_axi_wdata[6:0];
        `DDC_A_DECIM:  // factor held in 1..4096
          if (s_axi_wstrb[0])
            decim_q <= (s_axi_wdata[12:0] == '0) ? `DDC_DECIM_RST :
                       (s_axi_wdata[12:0] > `DDC_DECIM_MAX) ? `DDC_DECIM_MAX :
                       s_axi_wdata[12:0];
        `DDC_A_SHIFT:  if (s_axi_wstrb[0]) shift_q <= s_axi_wdata[5:0];
        `DDC_A_FHOLD:
          for (int b = 0; b < 4; b++)
            if (s_axi_wstrb[b]) fhold_q[8*b +: 8] <= s_axi_wdata[8*b +: 8];
        `DDC_A_TARGET: if (s_axi_wstrb[0]) target_q <= s_axi_wdata[15:0];
        `DDC_A_THRESH: if (s_axi_wstrb[0]) thresh_q <= s_axi_wdata[9:0];
        default: ;
      endcase

  // read channel, unmapped reads answer SLVERR with zero data
  always_ff @(posedge aclk)
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= `DDC_RESP_OK;
    end
    else
    begin
      s_axi_arready <= rd_go;
      if (rd_go)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `DDC_RESP_OK;
        unique case (s_axi_araddr)
          `DDC_A_CTRL:   s_axi_rdata <= {25'h0, ctrl_q};
          `DDC_A_DECIM:  s_axi_rdata <= {19'h0, decim_q};
          `DDC_A_SHIFT:  s_axi_rdata <= {26'h0, shift_q};
          `DDC_A_FHOLD:  s_axi_rdata <= fhold_q;
          `DDC_A_TARGET: s_axi_rdata <= {16'h0, target_q};
          `DDC_A_THRESH: s_axi_rdata <= {22'h0, thresh_q};
          `DDC_A_STATUS: s_axi_rdata <= {23'h0, if_level_high_q, gain_q};
          `DDC_A_OUT:    s_axi_rdata <= {out_q_q, out_i_q};
          `DDC_A_FREQ:   s_axi_rdata <= freq_q;
          `DDC_A_OFS:    s_axi_rdata <= ofs_q;
          default:
          begin
            s_axi_rdata <= '0;
            s_axi_rresp <= `DDC_RESP_ERR;
          end
        endcase
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end

  // carrier frequency load from holding register
  always_ff @(posedge aclk)
    if (!aresetn)
      freq_q <= '0;
    else if (carrier_freq_load)
      freq_q <= fhold_q;

  // serial offset word, msb first after sync, applied when complete
  always_ff @(posedge aclk)
    if (!aresetn)
    begin
      ofs_cnt_q <= '0;
      ofs_sh_q  <= '0;
      ofs_q     <= '0;
    end
    else if (carrier_offset_sync)
      ofs_cnt_q <= `DDC_OFS_BITS;
    else if (ofs_cnt_q != '0)
    begin
      ofs_sh_q  <= {ofs_sh_q[30:0], carrier_offset_serial_in};
      ofs_cnt_q <= ofs_cnt_q - 6'h01;
      if (ofs_cnt_q == 6'h01)
        ofs_q <= {ofs_sh_q[30:0], carrier_offset_serial_in};
    end

  // capture stage, format conversion
  logic              cap_v_q;
  logic signed [9:0] smp_i_q, smp_q_q;
  always_ff @(posedge aclk)
    if (!aresetn)
    begin
      cap_v_q <= 1'b0;
      smp_i_q <= '0;
      smp_q_q <= '0;
    end
    else
    begin
      cap_v_q <= !sample_capture_enable_n;
      if (!sample_capture_enable_n)
      begin
        smp_i_q <= inphase_sample_in ^ {ctrl_q[`DDC_C_OFSBIN], 9'h000};
        smp_q_q <= quad_sample_in ^ {ctrl_q[`DDC_C_OFSBIN], 9'h000};
      end
    end

  // nco accumulator advances once per captured sample
  always_ff @(posedge aclk)
    if (!aresetn)
      phase_q <= '0;
    else if (cap_v_q)
      phase_q <= phase_q + freq_q + ofs_q;

  // quarter-wave lookup with phase rotation
  logic [5:0]         ph;
  logic signed [10:0] c_t, s_t, nco_c, nco_s;
  always_comb
  begin
    ph  = phase_q[`DDC_PHASE_TOP] + {carrier_phase_select, 4'h0};
    c_t = $signed({1'b0, COS_T[ph[3:0]]});
    s_t = (ph[3:0] == 4'h0) ? 11'sh000 : $signed({1'b0, COS_T[4'h0 - ph[3:0]]});
    unique case (ph[5:4])
      2'd0:
      begin
        nco_c = c_t;
        nco_s = s_t;
      end
      2'd1:
      begin
        nco_c = -s_t;
        nco_s = c_t;
      end
      2'd2:
      begin
        nco_c = -c_t;
        nco_s = -s_t;
      end
      2'd3:
      begin
        nco_c = s_t;
        nco_s = -c_t;
      end
    endcase
  end

  // complex mix to zero frequency, then gain correction
  logic signed [21:0] mi_w, mq_w;
  logic signed [15:0] mix_i_q, mix_q_q;
  logic signed [15:0] g_q [2];
  logic signed [24:0] gp_i, gp_q;
  logic               mix_v_q, g_v_q;
  assign mi_w = 22'(smp_i_q * nco_c) + 22'(smp_q_q * nco_s);
  assign mq_w = 22'(smp_q_q * nco_c) - 22'(smp_i_q * nco_s);
  assign gp_i = 25'(mix_i_q * $signed({1'b0, gain_q}));
  assign gp_q = 25'(mix_q_q * $signed({1'b0, gain_q}));
  always_ff @(posedge aclk)
    if (!aresetn)
    begin
      mix_v_q <= 1'b0;
      g_v_q   <= 1'b0;
      mix_i_q <= '0;
      mix_q_q <= '0;
      g_q[0]  <= '0;
      g_q[1]  <= '0;
    end
    else
    begin
      mix_v_q <= cap_v_q;
      g_v_q   <= mix_v_q;
      if (cap_v_q)
      begin
        mix_i_q <= 16'(mi_w >>> `DDC_MIX_SHIFT);
        mix_q_q <= 16'(mq_w >>> `DDC_MIX_SHIFT);
      end
      if (mix_v_q)
      begin
        g_q[0] <= 16'(gp_i >>> `DDC_GAIN_FRAC);
        g_q[1] <= 16'(gp_q >>> `DDC_GAIN_FRAC);
      end
    end

  // shared decimation counter with symbol loop nudges
  logic [12:0] cnt_q;
  logic [13:0] reload;
  logic        adv_q, ret_q, dump;
  assign dump = g_v_q && (cnt_q <= 13'h0001);
  always_comb
  begin
    reload = {1'b0, decim_q};
    if (ctrl_q[`DDC_C_TRACK] && adv_q && !ret_q && decim_q > `DDC_DECIM_RST)
      reload = reload - 14'h0001;
    else if (ctrl_q[`DDC_C_TRACK] && ret_q && !adv_q && decim_q < `DDC_DECIM_MAX)
      reload = reload + 14'h0001;
  end
  always_ff @(posedge aclk)
    if (!aresetn)
    begin
      cnt_q <= `DDC_DECIM_RST;
      adv_q <= 1'b0;
      ret_q <= 1'b0;
    end
    else
    begin
      // a nudge arriving on the dump cycle is kept for the next one
      adv_q <= symbol_advance || (adv_q && !dump);
      ret_q <= symbol_retard || (ret_q && !dump);
      if (dump)
        cnt_q <= reload[12:0];
      else if (g_v_q)
        cnt_q <= cnt_q - 13'h0001;
    end

  // per-path cic, compensation and bypass
  logic signed [15:0] filt_w [2];
  logic               cic_v_q;
  genvar ch;
  for (ch = 0; ch < 2; ch++)
  begin : g_path
    logic signed [51:0] in1_q, in2_q, in3_q, d1_q, d2_q, d3_q, c1, c2, c3, cic;
    logic signed [15:0] x0_q, x1_q, x2_q;
    logic signed [20:0] comp;
    assign c1   = in3_q - d1_q;
    assign c2   = c1 - d2_q;
    assign c3   = c2 - d3_q;
    assign cic  = (mode == DDC_DUMP) ? (in1_q - d1_q) >>> shift_q : c3 >>> shift_q;
    assign comp = 21'(x1_q * $signed({1'b0, `DDC_COMP_TAP})) - 21'(x0_q) - 21'(x2_q);
    always_ff @(posedge aclk)
      if (!aresetn)
      begin
        {in1_q, in2_q, in3_q, d1_q, d2_q, d3_q} <= '0;
        {x0_q, x1_q, x2_q} <= '0;
      end
      else if (g_v_q)
      begin
        in1_q <= in1_q + 52'(g_q[ch]);
        in2_q <= in2_q + in1_q;
        in3_q <= in3_q + in2_q;
        if (dump)
        begin
          d1_q <= (mode == DDC_DUMP) ? in1_q : in3_q;
          d2_q <= c1;
          d3_q <= c2;
          x0_q <= 16'(cic);
          x1_q <= x0_q;
          x2_q <= x1_q;
        end
      end
    assign filt_w[ch] = (mode == DDC_BYPASS) ? g_q[ch] :
                        ctrl_q[`DDC_C_COMP] ? 16'(comp >>> `DDC_COMP_DIV) : x0_q;
  end

  // filtered sample strobe: every gained sample in bypass, else each dump
  logic fv;
  assign fv = (mode == DDC_BYPASS) ? g_v_q : cic_v_q;
  always_ff @(posedge aclk)
    if (!aresetn)
      cic_v_q <= 1'b0;
    else
      cic_v_q <= dump && (mode != DDC_BYPASS);

  // agc steps gain one code per output toward target
  logic [16:0] mag;
  assign mag = 17'(filt_w[0][15] ? -filt_w[0] : filt_w[0]) +
               17'(filt_w[1][15] ? -filt_w[1] : filt_w[1]);
  always_ff @(posedge aclk)
    if (!aresetn)
      gain_q <= `DDC_GAIN_RST;
    else if (fv && ctrl_q[`DDC_C_AGC])
    begin
      if (mag > {1'b0, target_q} && gain_q > `DDC_GAIN_MIN)
        gain_q <= gain_q - 8'h01;
      else if (mag < {1'b0, target_q} && gain_q < `DDC_GAIN_MAX)
        gain_q <= gain_q + 8'h01;
    end

  // input level detector for external agc
  always_ff @(posedge aclk)
    if (!aresetn)
      if_level_high_q <= 1'b0;
    else if (cap_v_q)
      if_level_high_q <= (smp_i_q[9] ? 10'(-smp_i_q) : smp_i_q) > thresh_q;

  // output formatter, parallel word or msb-first serial
  ddc_ser_t    ser_st_q;
  logic [15:0] sh_i_q, sh_q_q;
  logic [4:0]  sc_q;
  always_ff @(posedge aclk)
    if (!aresetn)
    begin
      {out_i_q, out_q_q, sh_i_q, sh_q_q} <= '0;
      {out_ready_q, ser_i_q, ser_q_q} <= '0;
      sc_q     <= '0;
      ser_st_q <= DDC_SER_IDLE;
    end
    else
    begin
      out_ready_q <= fv;
      if (fv)
      begin
        out_i_q  <= filt_w[0];
        out_q_q  <= filt_w[1];
        sh_i_q   <= filt_w[0];
        sh_q_q   <= filt_w[1];
        sc_q     <= `DDC_SER_BITS;
        ser_st_q <= ctrl_q[`DDC_C_SERIAL] ? DDC_SER_SHIFT : DDC_SER_IDLE;
      end
      else
        unique case (ser_st_q)
          DDC_SER_IDLE:
          begin
            ser_i_q <= 1'b0;
            ser_q_q <= 1'b0;
          end
          DDC_SER_SHIFT:
          begin
            ser_i_q <= sh_i_q[15];
            ser_q_q <= sh_q_q[15];
            sh_i_q  <= {sh_i_q[14:0], 1'b0};
            sh_q_q  <= {sh_q_q[14:0], 1'b0};
            sc_q    <= sc_q - 5'h01;
            if (sc_q == 5'h01)
              ser_st_q <= DDC_SER_IDLE;
          end
        endcase
    end

  // checks
  capture_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    sample_capture_enable_n |=> $stable(smp_i_q) && $stable(smp_q_q))
    else $error("sample changed while capture disabled");
  nco_freeze_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !cap_v_q |=> $stable(phase_q))
    else $error("nco moved without a sample");
  freq_load_a: assert property (@(posedge aclk) disable iff (!aresetn)
    carrier_freq_load |=> freq_q == $past(fhold_q))
    else $error("carrier frequency not loaded");
  offset_late_a: assert property (@(posedge aclk) disable iff (!aresetn)
    carrier_offset_sync ##1 !carrier_offset_sync [*8] |-> $stable(ofs_q))
    else $error("offset applied before word complete");
  offset_apply_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ofs_cnt_q == 6'h01 && !carrier_offset_sync
      |=> ofs_q[0] == $past(carrier_offset_serial_in))
    else $error("last offset bit not applied");
  decim_range_a: assert property (@(posedge aclk) disable iff (!aresetn)
    decim_q >= `DDC_DECIM_RST && decim_q <= `DDC_DECIM_MAX)
    else $error("decimation factor out of range");
  bypass_rate_a: assert property (@(posedge aclk) disable iff (!aresetn)
    mode == DDC_BYPASS && g_v_q |=> out_ready_q && out_i_q == $past(g_q[0]))
    else $error("bypass output wrong");
  agc_down_a: assert property (@(posedge aclk) disable iff (!aresetn)
    fv && ctrl_q[`DDC_C_AGC] && mag > {1'b0, target_q} && gain_q > `DDC_GAIN_MIN
      |=> gain_q == $past(gain_q) - 8'h01)
    else $error("agc did not lower gain");
  offset_bin_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !sample_capture_enable_n && ctrl_q[`DDC_C_OFSBIN]
      |=> smp_i_q[9] != $past(inphase_sample_in[9]))
    else $error("offset binary not converted");
  bus_err_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_go && s_axi_awaddr > `DDC_A_THRESH |=> s_axi_bvalid && s_axi_bresp == `DDC_RESP_ERR)
    else $error("unmapped write not refused");
endmodule // ddc_frontend
`default_nettype wire

// ### verification/ddc_src_model.sv
// Purpose: converter and carrier loop stand-in for the front end
// Assumes: driven by bench task calls right after a rising edge
// Notes:   released lines show the inverse of their last value
`default_nettype none
module ddc_src_model (
  // clock
  input  wire logic  aclk,
  // converter sample bus
  output logic [9:0] inphase_sample_in,
  output logic [9:0] quad_sample_in,
  output logic       sample_capture_enable_n,
  // carrier tracking loop
  output logic       carrier_offset_serial_in,
  output logic       carrier_offset_sync
);
  timeunit 1ns;
  timeprecision 1ps;
  // all lines idle at start
  initial
  begin
    inphase_sample_in        = 10'h000;
    quad_sample_in           = 10'h000;
    sample_capture_enable_n  = 1'b1;
    carrier_offset_serial_in = 1'b0;
    carrier_offset_sync      = 1'b0;
  end
  // one sample with enable held low over one edge
  task automatic put(input logic [9:0] i, input logic [9:0] q);
    inphase_sample_in       <= i;
    quad_sample_in          <= q;
    sample_capture_enable_n <= 1'b0;
    @(posedge aclk);
  endtask
  // release the bus so stale words are not mistaken for data
  task automatic idle();
    inphase_sample_in       <= ~inphase_sample_in;
    quad_sample_in          <= ~quad_sample_in;
    sample_capture_enable_n <= 1'b1;
  endtask
  // sync one edge ahead, then the word msb first
  task automatic send_ofs(input logic [31:0] w);
    carrier_offset_sync <= 1'b1;
    @(posedge aclk);
    carrier_offset_sync <= 1'b0;
    for (int k = 31; k >= 0; k--)
    begin
      carrier_offset_serial_in <= w[k];
      @(posedge aclk);
    end
    carrier_offset_serial_in <= ~w[0];
  endtask
endmodule // ddc_src_model
`default_nettype wire

// ### verification/digital_downconverter_frontend_tb_top.sv
// Purpose: self-checking bench of the down-conversion front end
// Assumes: zero carrier phase gives a 510/512 mixer gain
// Notes:   registers over AXI4-Lite, samples from the source model
`include "ddc_defs.svh"
`default_nettype none
module digital_downconverter_frontend_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // bus, sample and output wiring
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, sample_capture_enable_n, carrier_freq_load;
  logic        carrier_offset_serial_in, carrier_offset_sync, symbol_advance, symbol_retard;
  logic        out_ready_q, ser_i_q, ser_q_q, if_level_high_q;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rv;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rr, carrier_phase_select;
  logic [9:0]  inphase_sample_in, quad_sample_in;
  logic [15:0] out_i_q, out_q_q, last_i, last_q, si, sq;
  int          failures, n_compared, n_out, n0, t;

  ddc_frontend dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .inphase_sample_in, .quad_sample_in,
    .sample_capture_enable_n, .carrier_phase_select, .carrier_freq_load,
    .carrier_offset_serial_in, .carrier_offset_sync, .symbol_advance, .symbol_retard,
    .out_i_q, .out_q_q, .out_ready_q, .ser_i_q, .ser_q_q, .if_level_high_q
  );
  ddc_src_model src (
    .aclk, .inphase_sample_in, .quad_sample_in, .sample_capture_enable_n,
    .carrier_offset_serial_in, .carrier_offset_sync
  );

  // clock
  always #12.5 aclk = ~aclk;
  // latch each output word and count them
  always @(posedge aclk)
  begin
    if (out_ready_q === 1'b1)
    begin
      last_i <= out_i_q;
      last_q <= out_q_q;
      n_out  <= n_out + 1;
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one AXI4-Lite transfer, valids held until their ready
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic [1:0] r);
    logic dn;
    dn = 1'b0;
    s_axi_awaddr  <= a;
    s_axi_araddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= w;
    s_axi_wvalid  <= w;
    s_axi_bready  <= w;
    s_axi_arvalid <= !w;
    s_axi_rready  <= !w;
    for (int k = 0; k < 50 && !dn; k++)
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if ((w ? s_axi_bvalid : s_axi_rvalid) === 1'b1)
      begin
        dn = 1'b1;
        q  = s_axi_rdata;
        r  = w ? s_axi_bresp : s_axi_rresp;
      end
    end
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
    if (!dn) chk("bus answer", 32'h0000_0001, 32'h0000_0000);
    @(posedge aclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    bus(1'b1, a, d, rv, rr);
    chk("bresp", e, rr);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    bus(1'b0, a, 32'h0000_0000, rv, rr);
    chk("rresp", er, rr);
    chk("rdata", e, rv);
  endtask
  // n samples back to back, then let the pipeline drain
  task automatic run(input int n, input logic [9:0] i, input logic [9:0] q);
    repeat (n) src.put(i, q);
    src.idle();
    repeat (12) @(posedge aclk);
  endtask
  // k times one mixed and gain-corrected sample
  function automatic logic [15:0] mx(input int x, input int k);
    int p;
    p = k * ((x * 510) >>> 9);
    return p[15:0];
  endfunction
  task automatic wrap_up();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // cut a hang short
  initial
  begin
    repeat (20000) @(posedge aclk);
    failures++;
    wrap_up();
  end

  // main sequence
  initial
  begin
    aclk = 1'b0;
    aresetn = 1'b0;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'hF;
    carrier_phase_select = 2'h0;
    carrier_freq_load = 1'b0;
    symbol_advance = 1'b0;
    symbol_retard = 1'b0;
    n_out = 0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    // reset values and refused places
    rd(`DDC_A_CTRL, 32'h0000_0004, `DDC_RESP_OK);
    rd(`DDC_A_DECIM, 32'h0000_0001, `DDC_RESP_OK);
    rd(8'h28, 32'h0000_0000, `DDC_RESP_ERR);
    wr(`DDC_A_STATUS, 32'h0000_0000, `DDC_RESP_ERR);
    // bypass at phase 0 and 180 degrees
    wr(`DDC_A_CTRL, 32'h0000_0000, `DDC_RESP_OK);
    for (int k = 0; k < 4; k += 2)
    begin
      carrier_phase_select <= k[1:0];
      run(1, 10'h064, 10'h338);
      chk("out_i", mx(k > 0 ? -100 : 100, 1), {16'h0000, last_i});
      chk("out_q", mx(k > 0 ? 200 : -200, 1), {16'h0000, last_q});
    end
    carrier_phase_select <= 2'h0;
    // enable high holds everything
    n0 = n_out;
    repeat (20) @(posedge aclk);
    chk("n_out", n0, n_out);
    // offset binary input
    wr(`DDC_A_CTRL, 32'h0000_0001, `DDC_RESP_OK);
    run(1, 10'h264, 10'h138);
    chk("out_i", mx(100, 1), {16'h0000, last_i});
    chk("out_q", mx(-200, 1), {16'h0000, last_q});
    // input level detector
    wr(`DDC_A_THRESH, 32'h0000_0032, `DDC_RESP_OK);
    run(1, 10'h264, 10'h200);
    chk("level", 32'h0000_0001, if_level_high_q);
    run(1, 10'h214, 10'h200);
    chk("level", 32'h0000_0000, if_level_high_q);
    rd(`DDC_A_STATUS, 32'h0000_0080, `DDC_RESP_OK);
    // serial output, msb first after the ready cycle
    wr(`DDC_A_CTRL, 32'h0000_0010, `DDC_RESP_OK);
    src.put(10'h064, 10'h338);
    src.idle();
    for (t = 0; t < 20 && out_ready_q !== 1'b1; t++)
      @(posedge aclk);
    for (int k = 0; k < 16; k++)
    begin
      @(posedge aclk);
      si = {si[14:0], ser_i_q};
      sq = {sq[14:0], ser_q_q};
    end
    chk("ser_i", mx(100, 1), {16'h0000, si});
    chk("ser_q", mx(-200, 1), {16'h0000, sq});
    // integrate and dump by 4
    wr(`DDC_A_SHIFT, 32'h0000_0000, `DDC_RESP_OK);
    wr(`DDC_A_CTRL, 32'h0000_0042, `DDC_RESP_OK);
    wr(`DDC_A_DECIM, 32'h0000_0004, `DDC_RESP_OK);
    // one advance nudge shortens the first period to 3: dumps at 1, 4, 8
    n0 = n_out;
    symbol_advance <= 1'b1;
    @(posedge aclk);
    symbol_advance <= 1'b0;
    run(8, 10'h064, 10'h000);
    chk("n_out", n0 + 3, n_out);
    n0 = n_out;
    run(16, 10'h064, 10'h000);
    chk("n_out", n0 + 4, n_out);
    chk("out_i", mx(100, 4), {16'h0000, last_i});
    // third-order cic by 2, then with compensation
    wr(`DDC_A_CTRL, 32'h0000_0004, `DDC_RESP_OK);
    wr(`DDC_A_DECIM, 32'h0000_0002, `DDC_RESP_OK);
    run(16, 10'h064, 10'h000);
    chk("out_i", mx(100, 8), {16'h0000, last_i});
    wr(`DDC_A_CTRL, 32'h0000_000C, `DDC_RESP_OK);
    run(16, 10'h064, 10'h000);
    chk("out_i", mx(100, 8), {16'h0000, last_i});
    // decimation clamps at both ends
    wr(`DDC_A_DECIM, 32'h0000_0000, `DDC_RESP_OK);
    rd(`DDC_A_DECIM, 32'h0000_0001, `DDC_RESP_OK);
    wr(`DDC_A_DECIM, 32'h0000_1FFF, `DDC_RESP_OK);
    rd(`DDC_A_DECIM, 32'h0000_1000, `DDC_RESP_OK);
    // carrier load, kept low during every register write
    wr(`DDC_A_FHOLD, 32'h1234_5678, `DDC_RESP_OK);
    rd(`DDC_A_FREQ, 32'h0000_0000, `DDC_RESP_OK);
    carrier_freq_load <= 1'b1;
    @(posedge aclk);
    carrier_freq_load <= 1'b0;
    @(posedge aclk);
    rd(`DDC_A_FREQ, 32'h1234_5678, `DDC_RESP_OK);
    // serial carrier offset, old value kept until the word is whole
    fork
      src.send_ofs(32'hA5C3_0F96);
      rd(`DDC_A_OFS, 32'h0000_0000, `DDC_RESP_OK);
    join
    rd(`DDC_A_OFS, 32'hA5C3_0F96, `DDC_RESP_OK);
    // agc with zero target lowers gain once per output
    wr(`DDC_A_CTRL, 32'h0000_0020, `DDC_RESP_OK);
    run(4, 10'h064, 10'h000);
    rd(`DDC_A_STATUS, 32'h0000_017C, `DDC_RESP_OK);
    wrap_up();
  end
endmodule // digital_downconverter_frontend_tb_top
`default_nettype wire
